// file: dv/i2c_link_sva.sv
// checker of the two-wire link signals, sampled on the system clock
`timescale 1ns/10ps
`default_nettype none
module i2c_link_sva (
    input wire logic CLK_SYS,
    input wire logic RST,
    input wire logic scl,
    input wire logic sda,
    input wire logic s_sda_o,
    input wire logic s_scl_o,
    input wire logic s_sda_oe,
    input wire logic s_scl_oe,
    input wire logic m_scl_oe
);
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (RST);

    logic       scl_q;
    logic       sda_q;
    logic [3:0] edge_q;
    logic [9:0] ack_q;

    // bit position since start: rises 1..8 are data, 9 is the ack slot
    always_ff @(posedge CLK_SYS) begin
        scl_q <= scl;
        sda_q <= sda;
        if (RST || (scl && scl_q && sda_q && !sda)) begin
            edge_q <= 4'h0;
        end else if (scl && !scl_q) begin
            edge_q <= (edge_q == 4'h9) ? 4'h1 : edge_q + 4'h1;
        end
    end

    // length of the ack pull-down, saturating so it never wraps
    always_ff @(posedge CLK_SYS) begin
        if (RST || !s_sda_oe) begin
            ack_q <= 10'h000;
        end else if (ack_q != 10'h3ff) begin
            ack_q <= ack_q + 10'h001;
        end
    end

    property p_ack_at_eighth;
        $rose(s_sda_oe) |-> edge_q == 4'h8 && !scl;
    endproperty
    a_ack_at_eighth: assert property (p_ack_at_eighth) else $error("ack not after eighth bit");
    property p_ack_release;
        $fell(s_sda_oe) |-> edge_q == 4'h9 && !scl;
    endproperty
    a_ack_release: assert property (p_ack_release) else $error("ack not released after ninth fall");
    property p_ack_length;
        $fell(s_sda_oe) |-> ack_q >= 10'd390 && ack_q <= 10'd420;
    endproperty
    a_ack_length: assert property (p_ack_length) else $error("ack slot length wrong");
    property p_ack_steady;
        scl && scl_q && $past(s_sda_oe) |-> s_sda_oe;
    endproperty
    a_ack_steady: assert property (p_ack_steady) else $error("ack dropped while clock high");
    property p_no_drive_high;
        scl && scl_q && !$past(s_sda_oe) |-> !s_sda_oe;
    endproperty
    a_no_drive_high: assert property (p_no_drive_high) else $error("slave drove data in clock high");
    property p_drive_low_only;
        (s_sda_oe || s_scl_oe) |-> !(s_sda_o || s_scl_o);
    endproperty
    a_drive_low_only: assert property (p_drive_low_only) else $error("slave drove a line high");
    property p_stretch_ninth;
        $rose(s_scl_oe) |-> edge_q == 4'h9 && !scl;
    endproperty
    a_stretch_ninth: assert property (p_stretch_ninth) else $error("stretch outside ninth low");
    property p_stretch_hold;
        s_scl_oe && $past(s_scl_oe) && !$past(m_scl_oe) |-> !m_scl_oe;
    endproperty
    a_stretch_hold: assert property (p_stretch_hold) else $error("master pulled clock in stretch");
endmodule : i2c_link_sva
`default_nettype wire

// file: dv/i2c_slave_address_receive_tb_top.sv
// bench joining master and slave ends, judged through the slave registers
`timescale 1ns/10ps
`default_nettype none
`include "i2c_slave_cfg.svh"
module i2c_slave_address_receive_tb_top;
    localparam logic [7:0] M_BF = 8'h01 << `STAT_BF;
    localparam logic [7:0] M_UA = 8'h01 << `STAT_UA;
    localparam logic [7:0] M_RW = 8'h01 << `STAT_RW;
    localparam logic [7:0] M_OV = 8'h01 << `STAT_OV;
    localparam logic [7:0] M_IF = 8'h01 << `STAT_IF;
    logic       clk_sys, rst, link_clk, wr, rd, cmd_valid, cmd_start, cmd_stop;
    logic       cmd_ready, done, acked;
    logic [3:0] addr;
    logic [7:0] wdata, rdata, cmd_byte, v;
    int         error_cnt, total_checks, cyc;
    i2c_link_if link ();
    i2c_host_end i2c_host_end_i (.CLK_SYS(clk_sys), .RST(rst), .CMD_VALID(cmd_valid), .CMD_START(cmd_start),
        .CMD_STOP(cmd_stop), .CMD_BYTE(cmd_byte), .CMD_READY(cmd_ready), .DONE(done), .ACKED(acked), .bus(link));
    i2c_slave_end i2c_slave_end_i (.CLK_SYS(clk_sys), .RST(rst), .LINK_CLK(link_clk), .ADDR(addr),
        .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .bus(link));
    i2c_link_sva i2c_link_sva_i (.CLK_SYS(clk_sys), .RST(rst), .scl(link.scl), .sda(link.sda),
        .s_sda_o(link.s_sda_o), .s_scl_o(link.s_scl_o), .s_sda_oe(link.s_sda_oe), .s_scl_oe(link.s_scl_oe),
        .m_scl_oe(link.m_scl_oe));

    // two unrelated clocks; the link clock runs free
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    initial begin
        link_clk = 1'b0;
        #1.7;
        forever #3 link_clk = ~link_clk;
    end
    // hang guard, well above the longest expected run
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 90000) begin
            error_cnt = error_cnt + 1;
            final_report();
        end
    end

    // ----------
    // tasks
    // ----------
    task automatic chk(input logic [7:0] s, input logic [7:0] e);
        total_checks++;
        if (s !== e) begin
            error_cnt++;
            $display("unexpected at %0t: seen %h expected %h", $time, s, e);
        end
    endtask : chk
    task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk_sys);
        wr <= 1'b0;
    endtask : reg_wr
    // read data stand only in the cycle after the strobe
    task automatic rchk(input logic [3:0] a, input logic [7:0] e);
        @(posedge clk_sys);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk_sys);
        rd <= 1'b0;
        #1;
        v = rdata;
        chk(v, e);
    endtask : rchk
    task automatic issue(input logic s, input logic p, input logic [7:0] b);
        while (cmd_ready !== 1'b1) begin
            @(posedge clk_sys);
            #1;
        end
        @(posedge clk_sys);
        cmd_valid <= 1'b1;
        cmd_start <= s;
        cmd_stop  <= p;
        cmd_byte  <= b;
        @(posedge clk_sys);
        cmd_valid <= 1'b0;
    endtask : issue
    // waits for the ack slot, then lets the flags cross over
    task automatic wait_done(input logic e);
        int n;
        n = 0;
        while (done !== 1'b1 && n < 20000) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        if (done !== 1'b1) begin
            error_cnt++;
            final_report();
        end
        chk({7'h00, acked}, {7'h00, e});
        repeat (20) @(posedge clk_sys);
    endtask : wait_done
    task automatic xfer(input logic s, input logic p, input logic [7:0] b, input logic e);
        issue(s, p, b);
        wait_done(e);
    endtask : xfer
    // ten-bit address byte: acked, flags up, slave holds the clock after the ninth fall
    task automatic ten_step(input logic s, input logic [7:0] b);
        xfer(s, 1'b0, b, 1'b1);
        rchk(`ADR_STAT, M_BF | M_UA | M_IF);
        chk({7'h00, link.s_scl_oe}, 8'h01);
    endtask : ten_step
    // address swap releases the held clock, then the byte is serviced
    task automatic ten_swap(input logic [7:0] own, input logic [7:0] b);
        reg_wr(`ADR_OWN, own);
        repeat (10) @(posedge clk_sys);
        chk({7'h00, link.s_scl_oe}, 8'h00);
        rchk(`ADR_STAT, M_BF | M_IF);
        rchk(`ADR_RXBUF, b);
        reg_wr(`ADR_STAT, M_IF);
    endtask : ten_swap

    // ----------
    // scenarios
    // ----------
    task automatic t_seven();
        reg_wr(`ADR_CTRL, 8'h01);
        reg_wr(`ADR_OWN, 8'ha4);
        xfer(1'b1, 1'b0, 8'ha4, 1'b1);
        rchk(`ADR_STAT, M_BF | M_IF);
        rchk(`ADR_RXBUF, 8'ha4);
        rchk(`ADR_STAT, M_IF);
        reg_wr(`ADR_STAT, M_IF);
        xfer(1'b0, 1'b0, 8'h3c, 1'b1);
        rchk(`ADR_STAT, M_BF | M_IF);
        reg_wr(`ADR_STAT, M_IF);
        xfer(1'b0, 1'b0, 8'h5a, 1'b0);
        rchk(`ADR_STAT, M_BF | M_OV | M_IF);
        rchk(`ADR_RXBUF, 8'h3c);
        reg_wr(`ADR_STAT, M_IF);
        rchk(`ADR_STAT, M_OV);
        xfer(1'b0, 1'b1, 8'h77, 1'b0);
        rchk(`ADR_RXBUF, 8'h77);
        reg_wr(`ADR_STAT, M_OV | M_IF);
        rchk(`ADR_STAT, 8'h00);
    endtask : t_seven
    task automatic t_match();
        xfer(1'b1, 1'b1, 8'h30, 1'b0);
        rchk(`ADR_STAT, 8'h00);
        xfer(1'b1, 1'b1, 8'ha5, 1'b1);
        rchk(`ADR_STAT, M_BF | M_RW | M_IF);
        rchk(`ADR_RXBUF, 8'ha5);
        reg_wr(`ADR_STAT, M_IF);
    endtask : t_match
    task automatic t_ten();
        reg_wr(`ADR_CTRL, 8'h03);
        reg_wr(`ADR_OWN, 8'hf2);
        ten_step(1'b1, 8'hf2);
        ten_swap(8'h5b, 8'hf2);
        ten_step(1'b0, 8'h5b);
        // the master has let go here, so only the slave can keep the clock low
        issue(1'b1, 1'b1, 8'hf3);
        repeat (300) @(posedge clk_sys);
        chk({7'h00, link.scl}, 8'h00);
        ten_swap(8'hf2, 8'h5b);
        wait_done(1'b1);
        rchk(`ADR_STAT, M_BF | M_RW | M_IF);
        rchk(`ADR_RXBUF, 8'hf3);
    endtask : t_ten
    task automatic final_report();
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : final_report

    // reset, register defaults and an unmapped place, then the scenarios
    initial begin
        {wr, rd, cmd_valid, cmd_start, cmd_stop} = 5'h00;
        {addr, wdata, cmd_byte} = 20'h00000;
        error_cnt    = 0;
        total_checks = 0;
        cyc          = 0;
        rst = 1'b1;
        repeat (10) @(posedge clk_sys);
        rst <= 1'b0;
        repeat (10) @(posedge clk_sys);
        rchk(`ADR_CTRL, {6'h00, `CTRL_RST});
        rchk(`ADR_OWN, `OWN_RST);
        rchk(`ADR_STAT, 8'h00);
        reg_wr(4'h2, 8'hff);
        rchk(4'h2, 8'h00);
        t_seven();
        t_match();
        t_ten();
        final_report();
    end
endmodule : i2c_slave_address_receive_tb_top
`default_nettype wire

// file: include/i2c_link_if.sv
// open-drain two-wire link joining master and slave
`timescale 1ns/10ps
`default_nettype none
interface i2c_link_if;
    logic m_scl_o;
    logic m_scl_oe;
    logic m_sda_o;
    logic m_sda_oe;
    logic s_scl_o;
    logic s_scl_oe;
    logic s_sda_o;
    logic s_sda_oe;
    logic scl;
    logic sda;

    // wired-and: a line is low when any enabled driver pulls it low
    assign scl = (~m_scl_oe | m_scl_o) & (~s_scl_oe | s_scl_o);
    assign sda = (~m_sda_oe | m_sda_o) & (~s_sda_oe | s_sda_o);

    modport dev (input scl, input sda, output s_scl_o, output s_scl_oe, output s_sda_o, output s_sda_oe);
    modport ctl (input scl, input sda, output m_scl_o, output m_scl_oe, output m_sda_o, output m_sda_oe);
endinterface : i2c_link_if
`default_nettype wire

// file: include/i2c_slave_cfg.svh
// constants of the two-wire slave port and its bench-side master
`ifndef I2C_SLAVE_CFG_SVH
`define I2C_SLAVE_CFG_SVH

// ----------------------------------------
// register offsets on the software port
// ----------------------------------------
`define ADR_CTRL    4'h0
`define ADR_STAT    4'h4
`define ADR_OWN     4'h8
`define ADR_RXBUF   4'hc

// ----------------------------------------
// field positions and reset values
// ----------------------------------------
`define CTRL_EN     0
`define CTRL_TEN    1
`define STAT_BF     0
`define STAT_UA     1
`define STAT_RW     2
`define STAT_OV     3
`define STAT_IF     4
`define CTRL_RST    2'h0
`define OWN_RST     8'h00
`define TEN_PREFIX  5'h1e

// ----------------------------------------
// timing of the master's clock generator
// ----------------------------------------
`define SYS_PERIOD_NS  25
`define SCL_HALF_NS    5000
`define SCL_HALF_CYC   ((`SCL_HALF_NS + `SYS_PERIOD_NS - 1) / `SYS_PERIOD_NS)
`define BYTE_BITS      4'h8

`endif

// file: include/i2c_slave_pkg.sv
// types shared by both ends of the two-wire link
package i2c_slave_pkg;
    typedef enum logic [4:0] {
        L_IDLE  = 5'h01,
        L_SHIFT = 5'h02,
        L_ACK   = 5'h04,
        L_HOLD  = 5'h08,
        L_SKIP  = 5'h10
    } link_state_t;

    typedef enum logic [2:0] {
        P_ADDR1 = 3'h1,
        P_ADDR2 = 3'h2,
        P_DATA  = 3'h4
    } phase_t;

    typedef enum logic [4:0] {
        H_IDLE  = 5'h01,
        H_START = 5'h02,
        H_LOW   = 5'h04,
        H_HIGH  = 5'h08,
        H_STOP  = 5'h10
    } host_state_t;
endpackage : i2c_slave_pkg

// file: rtl/i2c_host_end.sv
// bus master end: sends bytes with start, stop and clock stretching support
`timescale 1ns/10ps
`default_nettype none
`include "i2c_slave_cfg.svh"
module i2c_host_end
    import i2c_slave_pkg::*;
(
    input  wire logic       CLK_SYS,
    input  wire logic       RST,
    input  wire logic       CMD_VALID,
    input  wire logic       CMD_START,
    input  wire logic       CMD_STOP,
    input  wire logic [7:0] CMD_BYTE,
    output logic            CMD_READY,
    output logic            DONE,
    output logic            ACKED,
    i2c_link_if.ctl         bus
);
    localparam logic [15:0] HALF = 16'(`SCL_HALF_CYC);

    host_state_t st_q;
    logic [1:0]  scl_sy_q;
    logic [1:0]  sda_sy_q;
    logic [15:0] cnt_q;
    logic [3:0]  bit_q;
    logic [1:0]  step_q;
    logic [7:0]  byte_q;
    logic        stop_q;
    logic        busy_q;
    logic        scl_oe_q;
    logic        sda_oe_q;
    logic        tick;

    // ----------------------------------------
    // line sampling
    // ----------------------------------------
    // lines are driven from the slave's clock, so resynchronise both
    always_ff @(posedge CLK_SYS) begin
        scl_sy_q <= {scl_sy_q[0], bus.scl};
        sda_sy_q <= {sda_sy_q[0], bus.sda};
    end

    // the half period runs while the master pulls the clock low or the line is really high, so a stretch pauses it
    assign tick = (cnt_q == HALF - 16'h0001) && (scl_oe_q || scl_sy_q[1]);

    always_ff @(posedge CLK_SYS) begin
        // held at zero in idle so every phase starts with a full half period
        if (RST || tick || (st_q == H_IDLE)) begin
            cnt_q <= 16'h0000;
        end else if (scl_oe_q || scl_sy_q[1]) begin
            cnt_q <= cnt_q + 16'h0001;
        end
    end

    // ----------------------------------------
    // byte sequencer
    // ----------------------------------------
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            st_q     <= H_IDLE;
            bit_q    <= 4'h0;
            step_q   <= 2'h0;
            byte_q   <= 8'h00;
            stop_q   <= 1'b0;
            busy_q   <= 1'b0;
            scl_oe_q <= 1'b0;
            sda_oe_q <= 1'b0;
            DONE     <= 1'b0;
            ACKED    <= 1'b0;
        end else begin
            DONE <= 1'b0;
            unique case (st_q)
                H_IDLE: begin
                    if (CMD_VALID) begin
                        byte_q <= CMD_BYTE;
                        stop_q <= CMD_STOP;
                        bit_q  <= 4'h0;
                        step_q <= 2'h0;
                        st_q   <= (CMD_START || !busy_q) ? H_START : H_LOW;
                    end
                end
                H_START: begin
                    if (step_q == 2'h0) begin
                        sda_oe_q <= 1'b0;
                    end else if (step_q == 2'h1) begin
                        scl_oe_q <= 1'b0;
                    end else begin
                        sda_oe_q <= 1'b1; // data falls while clock high
                    end
                    if (tick) begin
                        step_q <= step_q + 2'h1;
                        if (step_q == 2'h2) begin
                            busy_q <= 1'b1;
                            st_q   <= H_LOW;
                        end
                    end
                end
                H_LOW: begin
                    scl_oe_q <= 1'b1;
                    if (cnt_q == 16'h0000) begin
                        // release data for the acknowledge slot
                        sda_oe_q <= (bit_q == `BYTE_BITS) ? 1'b0 : ~byte_q[7];
                    end
                    if (tick) begin
                        st_q <= H_HIGH;
                    end
                end
                H_HIGH: begin
                    scl_oe_q <= 1'b0;
                    if (tick) begin
                        if (bit_q == `BYTE_BITS) begin
                            scl_oe_q <= 1'b1; // ninth fall; clock stays low between bytes
                            ACKED  <= ~sda_sy_q[1];
                            DONE   <= 1'b1;
                            step_q <= 2'h0;
                            st_q   <= stop_q ? H_STOP : H_IDLE;
                        end else begin
                            byte_q <= {byte_q[6:0], 1'b0};
                            bit_q  <= bit_q + 4'h1;
                            st_q   <= H_LOW;
                        end
                    end
                end
                H_STOP: begin
                    if (step_q == 2'h0) begin
                        scl_oe_q <= 1'b1;
                        sda_oe_q <= 1'b1;
                    end else if (step_q == 2'h1) begin
                        scl_oe_q <= 1'b0;
                    end else begin
                        sda_oe_q <= 1'b0; // data rises while clock high
                    end
                    if (tick) begin
                        step_q <= step_q + 2'h1;
                        if (step_q == 2'h2) begin
                            busy_q <= 1'b0;
                            st_q   <= H_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    assign CMD_READY    = (st_q == H_IDLE);
    assign bus.m_scl_o  = 1'b0;
    assign bus.m_sda_o  = 1'b0;
    assign bus.m_scl_oe = scl_oe_q;
    assign bus.m_sda_oe = sda_oe_q;
endmodule : i2c_host_end
`default_nettype wire

// file: rtl/i2c_slave_end.sv
// slave end: address match, receive buffer, status flags and clock stretch
`timescale 1ns/10ps
`default_nettype none
`include "i2c_slave_cfg.svh"
module i2c_slave_end
    import i2c_slave_pkg::*;
(
    input  wire logic       CLK_SYS,
    input  wire logic       RST,
    input  wire logic       LINK_CLK,
    input  wire logic [3:0] ADDR,
    input  wire logic [7:0] WDATA,
    input  wire logic       WR,
    input  wire logic       RD,
    output logic      [7:0] RDATA,
    i2c_link_if.dev         bus
);
    // ----------------------------------------
    // system domain state
    // ----------------------------------------
    logic [1:0] ctrl_q;
    logic [7:0] own_q;
    logic [7:0] buf_q;
    logic       bf_q;
    logic       ov_q;
    logic       if_q;
    logic       ua_q;
    logic       rw_q;
    logic       own_tgl_q;
    logic [2:0] ev_sy_q;
    logic [2:0] irq_sy_q;
    logic       ev_p;
    logic       irq_p;
    logic       wr_ctrl;
    logic       wr_stat;
    logic       wr_own;
    logic       rd_buf;

    // ----------------------------------------
    // link domain state
    // ----------------------------------------
    link_state_t st_q;
    phase_t      ph_q;
    logic [1:0]  rst_sy_q;
    logic [1:0]  scl_sy_q;
    logic [1:0]  sda_sy_q;
    logic        scl_q;
    logic        sda_q;
    logic [3:0]  cs1_q;
    logic [3:0]  cs2_q;
    logic        own_seen_q;
    logic [7:0]  own_l_q;
    logic        upd_pend_q;
    logic [7:0]  sr_q;
    logic [3:0]  cnt_q;
    logic        m10_q;
    logic        stretch_q;
    logic        to_skip_q;
    logic        ack_oe_q;
    logic        hold_oe_q;
    logic        ev_tgl_q;
    logic        irq_tgl_q;
    logic [7:0]  ev_byte_q;
    logic        ev_adr_q;
    logic        ev_ua_q;
    logic        rst_l;
    logic        scl_rise;
    logic        scl_fall;
    logic        start_c;
    logic        stop_c;
    logic        own_new;
    logic        take;
    logic        ua_set;
    logic        final_adr;
    phase_t      ph_nxt;

    // ----------------------------------------
    // software port decode
    // ----------------------------------------
    assign wr_ctrl = WR && (ADDR == `ADR_CTRL);
    assign wr_stat = WR && (ADDR == `ADR_STAT);
    assign wr_own  = WR && (ADDR == `ADR_OWN);
    assign rd_buf  = RD && (ADDR == `ADR_RXBUF);

    // event toggles from the link; the first stage feeds only the second
    always_ff @(posedge CLK_SYS) begin
        ev_sy_q  <= {ev_sy_q[1:0], ev_tgl_q};
        irq_sy_q <= {irq_sy_q[1:0], irq_tgl_q};
    end
    assign ev_p  = ev_sy_q[2] ^ ev_sy_q[1];
    assign irq_p = irq_sy_q[2] ^ irq_sy_q[1];

    // control and own address; each address write toggles a notice to the link
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            ctrl_q    <= `CTRL_RST;
            own_q     <= `OWN_RST;
            own_tgl_q <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                ctrl_q <= WDATA[1:0];
            end
            if (wr_own) begin
                own_q     <= WDATA;
                own_tgl_q <= ~own_tgl_q;
            end
        end
    end

    // receive buffer and full/overflow flags; a hardware set beats a clear
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            buf_q <= 8'h00;
            bf_q  <= 1'b0;
            ov_q  <= 1'b0;
        end else begin
            if (rd_buf) begin
                bf_q <= 1'b0;
            end
            if (wr_stat && WDATA[`STAT_OV]) begin
                ov_q <= 1'b0;
            end
            if (ev_p) begin
                if (bf_q) begin
                    ov_q <= 1'b1;
                end else begin
                    buf_q <= ev_byte_q;
                    bf_q  <= 1'b1;
                end
            end
        end
    end

    // interrupt, update-address and direction status
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            if_q <= 1'b0;
            ua_q <= 1'b0;
            rw_q <= 1'b0;
        end else begin
            if (wr_stat && WDATA[`STAT_IF]) begin
                if_q <= 1'b0;
            end
            if (wr_own) begin
                ua_q <= 1'b0;
            end
            if (irq_p || (ev_p && bf_q)) begin
                if_q <= 1'b1;
            end
            if (ev_p && ev_ua_q) begin
                ua_q <= 1'b1;
            end
            if (ev_p && ev_adr_q) begin
                rw_q <= ev_byte_q[0];
            end
        end
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge CLK_SYS) begin
        if (RST || !RD) begin
            RDATA <= 8'h00;
        end else begin
            unique case (ADDR)
                `ADR_CTRL:  RDATA <= {6'h00, ctrl_q};
                `ADR_STAT:  RDATA <= {3'h0, if_q, ov_q, rw_q, ua_q, bf_q};
                `ADR_OWN:   RDATA <= own_q;
                `ADR_RXBUF: RDATA <= buf_q;
                default:    RDATA <= 8'h00;
            endcase
        end
    end

    // ----------------------------------------
    // link side crossings
    // ----------------------------------------
    always_ff @(posedge LINK_CLK) begin
        rst_sy_q <= {rst_sy_q[0], RST};
        scl_sy_q <= {scl_sy_q[0], bus.scl};
        sda_sy_q <= {sda_sy_q[0], bus.sda};
        scl_q    <= scl_sy_q[1];
        sda_q    <= sda_sy_q[1];
        cs1_q    <= {own_tgl_q, bf_q | ov_q, ctrl_q[`CTRL_TEN], ctrl_q[`CTRL_EN]};
        cs2_q    <= cs1_q;
    end
    assign rst_l    = rst_sy_q[1];
    assign scl_rise = scl_sy_q[1] & ~scl_q;
    assign scl_fall = ~scl_sy_q[1] & scl_q;
    assign start_c  = scl_sy_q[1] & scl_q & sda_q & ~sda_sy_q[1];
    assign stop_c   = scl_sy_q[1] & scl_q & ~sda_q & sda_sy_q[1];
    assign own_new  = cs2_q[3] ^ own_seen_q;

    // own address copy; the register is stable long before the toggle lands
    always_ff @(posedge LINK_CLK) begin
        if (rst_l) begin
            own_seen_q <= 1'b0;
            own_l_q    <= `OWN_RST;
        end else if (own_new) begin
            own_seen_q <= cs2_q[3];
            own_l_q    <= own_q;
        end
    end

    // ----------------------------------------
    // address decode of the completed byte
    // ----------------------------------------
    always_comb begin
        take      = 1'b0;
        ua_set    = 1'b0;
        final_adr = 1'b0;
        ph_nxt    = P_DATA;
        unique case (ph_q)
            P_ADDR1: begin
                take = (sr_q[7:1] == own_l_q[7:1]);
                if (cs2_q[1] && !m10_q) begin
                    take   = take && (sr_q[7:3] == `TEN_PREFIX) && !sr_q[0];
                    ua_set = 1'b1;
                    ph_nxt = P_ADDR2;
                end else begin
                    final_adr = 1'b1;
                end
            end
            P_ADDR2: begin
                take      = (sr_q == own_l_q);
                ua_set    = 1'b1;
                // bit 0 of the low byte is address, not direction
            end
            P_DATA: take = 1'b1;
        endcase
    end

    // ----------------------------------------
    // link sequencer
    // ----------------------------------------
    always_ff @(posedge LINK_CLK) begin
        if (rst_l) begin
            st_q       <= L_IDLE;
            ph_q       <= P_ADDR1;
            sr_q       <= 8'h00;
            cnt_q      <= 4'h0;
            m10_q      <= 1'b0;
            stretch_q  <= 1'b0;
            to_skip_q  <= 1'b0;
            upd_pend_q <= 1'b0;
            ack_oe_q   <= 1'b0;
            hold_oe_q  <= 1'b0;
            ev_tgl_q   <= 1'b0;
            irq_tgl_q  <= 1'b0;
            ev_byte_q  <= 8'h00;
            ev_adr_q   <= 1'b0;
            ev_ua_q    <= 1'b0;
        end else if (!cs2_q[0]) begin
            st_q      <= L_IDLE;
            m10_q     <= 1'b0;
            ack_oe_q  <= 1'b0;
            hold_oe_q <= 1'b0;
        end else if (start_c) begin
            // a repeated start keeps the ten-bit match
            st_q      <= L_SHIFT;
            ph_q      <= P_ADDR1;
            cnt_q     <= 4'h0;
            ack_oe_q  <= 1'b0;
            hold_oe_q <= 1'b0;
        end else if (stop_c) begin
            st_q      <= L_IDLE;
            m10_q     <= 1'b0;
            ack_oe_q  <= 1'b0;
            hold_oe_q <= 1'b0;
        end else begin
            if (own_new) begin
                upd_pend_q <= 1'b1;
            end
            unique case (st_q)
                L_IDLE, L_SKIP: begin
                end
                L_SHIFT: begin
                    if (scl_rise && cnt_q != `BYTE_BITS) begin
                        sr_q  <= {sr_q[6:0], sda_sy_q[1]};
                        cnt_q <= cnt_q + 4'h1;
                    end
                    if (scl_fall && cnt_q == `BYTE_BITS) begin
                        if (take) begin
                            ack_oe_q  <= ~cs2_q[2];
                            ev_tgl_q  <= ~ev_tgl_q;
                            ev_byte_q <= sr_q;
                            ev_adr_q  <= (ph_q == P_ADDR1);
                            ev_ua_q   <= ua_set;
                            stretch_q <= ua_set;
                            to_skip_q <= final_adr && sr_q[0];
                            m10_q     <= m10_q || (ph_q == P_ADDR2);
                            ph_q      <= ph_nxt;
                            st_q      <= L_ACK;
                            if (ua_set) begin
                                upd_pend_q <= own_new;
                            end
                        end else begin
                            st_q <= L_SKIP;
                        end
                    end
                end
                L_ACK: begin
                    if (scl_fall) begin
                        ack_oe_q  <= 1'b0;
                        irq_tgl_q <= ~irq_tgl_q;
                        cnt_q     <= 4'h0;
                        if (stretch_q) begin
                            hold_oe_q <= 1'b1;
                            st_q      <= L_HOLD;
                        end else begin
                            st_q <= to_skip_q ? L_SKIP : L_SHIFT;
                        end
                    end
                end
                L_HOLD: begin
                    if (upd_pend_q || own_new) begin
                        hold_oe_q <= 1'b0;
                        st_q      <= to_skip_q ? L_SKIP : L_SHIFT;
                    end
                end
            endcase
        end
    end

    // released unless acknowledging or stretching
    assign bus.s_sda_o  = 1'b0;
    assign bus.s_scl_o  = 1'b0;
    assign bus.s_sda_oe = ack_oe_q;
    assign bus.s_scl_oe = hold_oe_q;
endmodule : i2c_slave_end
`default_nettype wire
